// *** rtl/gsg_cfg.svh ***
/*
 * Offsets, field positions and reset values of the global status
 * and pin control block. Assumes 16-bit registers on a 12-bit
 * byte-address microprocessor port.
 */
`ifndef GSG_CFG_SVH
`define GSG_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define GSG_OFS_FSEL    12'h00A
`define GSG_OFS_ISR     12'h010
`define GSG_OFS_ISRIE   12'h012
`define GSG_OFS_SR      12'h014
`define GSG_OFS_SRL     12'h016
`define GSG_OFS_SRIE    12'h018
`define GSG_OFS_PINRD   12'h01C

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define GSG_ISR_GSR     0
`define GSG_ISR_PORT_LO 4
`define GSG_SRL_DONE    0
`define GSG_SRL_UNLOCK  1
`define GSG_SRL_TICK    2
`define GSG_SRL_ADAPTER_REF_CLOCK_PIN    3
`define GSG_SRL_REF8K   4
`define GSG_RST_ISRIE   8'h00
`define GSG_RST_SRIE    3'h0
`define GSG_RST_FSEL    16'h0000
`define GSG_UPD_PIN     2'h1

`endif

// *** rtl/gsg_pkg.sv ***
/*
 * Types shared by the global status and pin control block.
 * Assumes nothing of its surroundings.
 */
package gsg_pkg;
   // Pin function select codes in order 00, 01, 10, 11
   typedef enum logic [1:0] {
      GSG_FN_INPUT,
      GSG_FN_STATUS,
      GSG_FN_LOW,
      GSG_FN_HIGH
   } gsg_pin_fn_t;
endpackage

// *** rtl/gsg_pin_sync.sv ***
/*
 * Three-flop input synchroniser with agreement filter.
 * Assumes inputs asynchronous to clk.
 */
`timescale 1ns/100ps
module gsg_pin_sync #(
   parameter int W = 8
) (
   // Clock, reset, enable
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Asynchronous levels in, filtered levels out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   wire  [W-1:0] agree = ~(s2_q ^ s3_q);

   // s1_q feeds s2_q only; the level moves once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         dout <= '0;
      end else if (ce) begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         dout <= (s3_q & agree) | (dout & ~agree);
      end
   end
endmodule

// *** rtl/gsg_global_status.sv ***
/*
 * Global status, interrupt tree and general-purpose pin control.
 * Assumes a 16-bit register port with one-cycle read and write
 * strobes on clk, and per-port summaries from logic on clk.
 */
// How it works
// - Two-bit pin select: input, status out, drive low, drive high.
// - Odd pins carry port A status, even pins port B status.
// - Pin 8 select applies unless update mode is 01; else input.
// - Pin 6 select applies unless error-insert source is set.
// - Pin 4 select applies unless 8 kHz input select is set.
// - Pin 2 select applies unless 8 kHz output select is set.
// - Summary bits 7..4 show any port status bit set.
// - Enabled port summary bit pulls interrupt pin low.
// - Global summary bit is any enabled latched status bit.
// - Enabled global summary bit pulls interrupt pin low.
// - Live bit 1 is high while any adapter PLL is unlocked.
// - Live bit 0 ANDs done bits of globally controlled ports.
// - Latched bit 4 on 8 kHz input activity, when selected.
// - Latched bit 3 on adapter reference clock pin activity.
// - Latched bit 2 set by each one-second tick.
// - Latched bit 1 set on rise of unlock, held until cleared.
// - Latched bit 0 set on rise of live update done.
// - Enables 2..0 gate latched bits; all enables reset to 0.
// - Pin readback register shows present level of pins 8..1.
// - Latched bits clear on write or on read by clear mode.
// - Interrupt pin drives low; idle is float or high by mode.
`timescale 1ns/100ps
`include "gsg_cfg.svh"
module gsg_global_status #(
   parameter int NPORT = 4,
   parameter int NPLL  = 3
) (
   // Clock, reset, enable
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // Register port
   input  wire logic [11:0]      addr,
   input  wire logic             wr_en,
   input  wire logic             rd_en,
   input  wire logic [15:0]      wdata,
   output logic      [15:0]      rdata,
   // Global control bits
   input  wire logic [1:0]       global_update_mode,
   input  wire logic             error_insert_source,
   input  wire logic             ref8k_input_sel,
   input  wire logic             ref8k_output_sel,
   input  wire logic             latched_clear_mode,
   input  wire logic             irq_pin_mode,
   // Port and timing sources
   input  wire logic [NPORT-1:0] port_irq_any,
   input  wire logic [NPORT-1:0] port_status_sel_a,
   input  wire logic [NPORT-1:0] port_status_sel_b,
   input  wire logic [NPORT-1:0] port_update_mode,
   input  wire logic [NPORT-1:0] port_update_done,
   input  wire logic [NPLL-1:0]  adapter_pll_locked,
   input  wire logic             second_tick,
   input  wire logic             ref8k_out,
   // Pins
   input  wire logic [7:0]       gpio_in,
   output logic      [7:0]       gpio_out,
   output logic      [7:0]       gpio_oe,
   input  wire logic             adapter_ref_clock_pin,
   output logic                  irq_n_out,
   output logic                  irq_n_oe,
   // Pin functions handed to other blocks
   output logic                  ext_update_trigger,
   output logic                  ext_error_insert,
   output logic                  ref8k_in
);
   import gsg_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0]  isrie_q;
   logic [2:0]  srie_q;
   logic [15:0] fsel_q;
   logic [4:0]  lat_q;
   logic        unlock_q;
   logic        done_q;
   logic        ref8k_prev_q;
   logic        adapter_ref_clock_pin_prev_q;
   logic [7:0]  pin_lvl;
   logic        adapter_ref_clock_pin_lvl;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   gsg_pin_sync #(.W(9)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .din  ({adapter_ref_clock_pin, gpio_in}),
      .dout ({adapter_ref_clock_pin_lvl, pin_lvl})
   );

   // ****************************************************************
   // Pin function decode
   // ****************************************************************
   wire       upd_pin  = (global_update_mode == `GSG_UPD_PIN);
   wire [7:0] ovr_in   = {upd_pin, 1'b0, error_insert_source, 1'b0,
                          ref8k_input_sel, 3'b000};
   wire [7:0] stat_sig;
   wire [7:0] pin_oe_d;
   wire [7:0] pin_out_d;

   function automatic logic fn_drive(input logic [1:0] sel,
                                     input logic       stat);
      unique case (gsg_pin_fn_t'(sel))
         GSG_FN_INPUT:  fn_drive = 1'b0;
         GSG_FN_STATUS: fn_drive = stat;
         GSG_FN_LOW:    fn_drive = 1'b0;
         GSG_FN_HIGH:   fn_drive = 1'b1;
      endcase
   endfunction

   for (genvar i = 0; i < 8; i++) begin : g_pin
      // Even index is an odd-numbered pin: port A; odd index: port B
      if (i % 2 == 0) begin : g_a
         assign stat_sig[i] = port_status_sel_a[i/2];
      end else begin : g_b
         assign stat_sig[i] = port_status_sel_b[i/2];
      end
      wire [1:0] sel = fsel_q[2*i+1:2*i];
      wire       use_ref = (i == 1) && ref8k_output_sel;
      assign pin_oe_d[i] = use_ref ||
         (!ovr_in[i] && sel != 2'(GSG_FN_INPUT));
      assign pin_out_d[i] = use_ref ? ref8k_out :
         (ovr_in[i] ? 1'b0 : fn_drive(sel, stat_sig[i]));
   end

   // ****************************************************************
   // Live status and latched events
   // ****************************************************************
   wire unlock_d = ~&adapter_pll_locked;
   wire done_d   = (|port_update_mode) &&
                   (&(port_update_done | ~port_update_mode));
   wire ref8k_mon = ref8k_input_sel ? pin_lvl[3] : 1'b0;

   wire [4:0] lat_set;
   // Previous level tracks the pad even while unmonitored, so turning
   // the input select on with the pad high is not taken as activity
   assign lat_set[`GSG_SRL_REF8K]  = ref8k_input_sel &&
                                     (pin_lvl[3] != ref8k_prev_q);
   assign lat_set[`GSG_SRL_ADAPTER_REF_CLOCK_PIN]   = adapter_ref_clock_pin_lvl != adapter_ref_clock_pin_prev_q;
   assign lat_set[`GSG_SRL_TICK]   = second_tick;
   assign lat_set[`GSG_SRL_UNLOCK] = unlock_d && !unlock_q;
   assign lat_set[`GSG_SRL_DONE]   = done_d && !done_q;

   wire hit_srl = (addr == `GSG_OFS_SRL);
   wire [4:0] lat_clr =
      (wr_en && hit_srl && !latched_clear_mode) ? wdata[4:0] :
      (rd_en && hit_srl && latched_clear_mode) ? 5'h1F : 5'h00;
   // An event in the clearing cycle survives: set is ORed after clear
   wire [4:0] lat_d = (lat_q & ~lat_clr) | lat_set;

   // ****************************************************************
   // Interrupt tree
   // ****************************************************************
   wire global_status_summary = |(lat_q[2:0] & srie_q);
   wire [3:0] port_sum = port_irq_any[3:0];
   wire irq_act = |(port_sum & isrie_q[7:4]) ||
                  (global_status_summary && isrie_q[`GSG_ISR_GSR]);

   // ****************************************************************
   // Register port
   // ****************************************************************
   wire [15:0] isr_val = {8'h00, port_sum, 3'b000, global_status_summary};
   wire [15:0] rd_mux =
      (addr == `GSG_OFS_FSEL)  ? fsel_q :
      (addr == `GSG_OFS_ISR)   ? isr_val :
      (addr == `GSG_OFS_ISRIE) ? {8'h00, isrie_q} :
      (addr == `GSG_OFS_SR)    ? {14'h0000, unlock_q, done_q} :
      (addr == `GSG_OFS_SRL)   ? {11'h000, lat_q} :
      (addr == `GSG_OFS_SRIE)  ? {13'h0000, srie_q} :
      (addr == `GSG_OFS_PINRD) ? {8'h00, pin_lvl} : 16'h0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         isrie_q <= `GSG_RST_ISRIE;
         srie_q  <= `GSG_RST_SRIE;
         fsel_q  <= `GSG_RST_FSEL;
      end else if (ce && wr_en) begin
         if (addr == `GSG_OFS_ISRIE)
            isrie_q <= wdata[7:0] & 8'hF1;
         if (addr == `GSG_OFS_SRIE)
            srie_q <= wdata[2:0];
         if (addr == `GSG_OFS_FSEL)
            fsel_q <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lat_q        <= 5'h00;
         unlock_q     <= 1'b0;
         done_q       <= 1'b0;
         ref8k_prev_q <= 1'b0;
         adapter_ref_clock_pin_prev_q  <= 1'b0;
         rdata        <= 16'h0000;
      end else if (ce) begin
         lat_q        <= lat_d;
         unlock_q     <= unlock_d;
         done_q       <= done_d;
         ref8k_prev_q <= pin_lvl[3];
         adapter_ref_clock_pin_prev_q  <= adapter_ref_clock_pin_lvl;
         if (rd_en)
            rdata <= rd_mux;
      end
   end

   // ****************************************************************
   // Pin and interrupt outputs
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_out           <= 8'h00;
         gpio_oe            <= 8'h00;
         irq_n_out          <= 1'b1;
         irq_n_oe           <= 1'b0;
         ext_update_trigger <= 1'b0;
         ext_error_insert   <= 1'b0;
         ref8k_in           <= 1'b0;
      end else if (ce) begin
         gpio_out           <= pin_out_d;
         gpio_oe            <= pin_oe_d;
         irq_n_out          <= !irq_act;
         irq_n_oe           <= irq_act || irq_pin_mode;
         ext_update_trigger <= upd_pin && pin_lvl[7];
         ext_error_insert   <= error_insert_source && pin_lvl[5];
         // Low when not selected, so ports see no stray reference
         ref8k_in           <= ref8k_mon;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_unlock_rise;
      ce && unlock_d && !unlock_q;
   endsequence
   sequence s_no_clear;
      ce && !(hit_srl && (wr_en || rd_en));
   endsequence

   unlock_latch_a: assert property (
      s_unlock_rise ##1 s_no_clear |-> lat_q[`GSG_SRL_UNLOCK] ##1
         lat_q[`GSG_SRL_UNLOCK])
      else $error("unlock rise not latched");
   tick_latch_a: assert property (
      ce && second_tick |=> lat_q[`GSG_SRL_TICK])
      else $error("second tick not latched");
   set_wins_a: assert property (
      ce && |lat_set |=> &(lat_q | ~$past(lat_set)))
      else $error("latched event lost on clear");
   read_clear_a: assert property (
      ce && rd_en && hit_srl && latched_clear_mode && !(|lat_set)
      |=> lat_q == 5'h00)
      else $error("clear on read failed");
   irq_drive_a: assert property (
      ce && irq_act |=> !irq_n_out && irq_n_oe)
      else $error("interrupt pin not driven low");
   irq_idle_a: assert property (
      ce && !irq_act && !irq_pin_mode |=> irq_n_out && !irq_n_oe)
      else $error("idle interrupt pin not floating");
   pin8_override_a: assert property (
      ce && upd_pin |=> !gpio_oe[7])
      else $error("pin 8 driven in update-pin mode");
   pin2_ref_a: assert property (
      ce && ref8k_output_sel |=> gpio_oe[1] &&
         gpio_out[1] == $past(ref8k_out))
      else $error("pin 2 not carrying reference");
   pin_high_a: assert property (
      ce && fsel_q[1:0] == 2'b11 |=> gpio_oe[0] && gpio_out[0])
      else $error("pin 1 not driven high");
   enable_reset_a: assert property (
      $fell(rst) |-> isrie_q == 8'h00 && srie_q == 3'h0)
      else $error("enables not cleared by reset");
   gsr_gate_a: assert property (
      srie_q == 3'h0 |-> !global_status_summary)
      else $error("summary set with all enables off");
endmodule

// *** verification/gsg_board.sv ***
/*
 * Board model: resolves the eight pad levels and the interrupt line.
 * Assumes the bench gives the level that board logic puts on each
 * pin that the device leaves undriven.
 */
`timescale 1ns/100ps
module gsg_board (
   // Device pin drive
   input  wire logic [7:0] gpio_out,
   input  wire logic [7:0] gpio_oe,
   input  wire logic       irq_n_out,
   input  wire logic       irq_n_oe,
   // Board drive
   input  wire logic [7:0] brd_val,
   // Resolved levels
   output logic      [7:0] pad,
   output logic            irq_pad
);
   // ***************************************************************
   // Wire resolution
   // ***************************************************************
   assign pad = (gpio_oe & gpio_out) | (~gpio_oe & brd_val);
   // Pull-up holds the released interrupt line high
   assign irq_pad = irq_n_oe ? irq_n_out : 1'b1;
endmodule

// *** verification/test_global_status_gpio_control.sv ***
/*
 * Self-checking bench for the global status and pin control block.
 * Assumes the design files and the board model are compiled first.
 */
`timescale 1ns/100ps
`include "gsg_cfg.svh"
module test_global_status_gpio_control;
   import gsg_pkg::*;
   logic        clk = 1'b0;
   logic        rst, ce, wr_en, rd_en, rd_p, second_tick, ref8k_out;
   logic [11:0] addr;
   logic [15:0] wdata, rdata;
   logic [1:0]  global_update_mode;
   logic        error_insert_source, ref8k_input_sel, ref8k_output_sel;
   logic        latched_clear_mode, irq_pin_mode, adapter_ref_clock_pin;
   logic [3:0]  port_irq_any, port_status_sel_a, port_status_sel_b;
   logic [3:0]  port_update_mode, port_update_done;
   logic [2:0]  adapter_pll_locked;
   logic [7:0]  pad, gpio_out, gpio_oe, brd_val, st, exp_o;
   logic        irq_n_out, irq_n_oe, irq_pad;
   logic        ext_update_trigger, ext_error_insert, ref8k_in;
   logic [15:0] exp_q[$];
   gsg_pin_fn_t fn;
   int          n_mismatch = 0;
   int          cmp_count = 0;

   gsg_global_status #(.NPORT(4), .NPLL(3)) dut_u (
      .clk, .rst, .ce, .addr, .wr_en, .rd_en, .wdata, .rdata,
      .global_update_mode, .error_insert_source, .ref8k_input_sel,
      .ref8k_output_sel, .latched_clear_mode, .irq_pin_mode,
      .port_irq_any, .port_status_sel_a, .port_status_sel_b,
      .port_update_mode, .port_update_done, .adapter_pll_locked,
      .second_tick, .ref8k_out, .gpio_in(pad), .gpio_out, .gpio_oe,
      .adapter_ref_clock_pin, .irq_n_out, .irq_n_oe,
      .ext_update_trigger, .ext_error_insert, .ref8k_in);
   gsg_board brd_u (.gpio_out, .gpio_oe, .irq_n_out, .irq_n_oe,
      .brd_val, .pad, .irq_pad);

   // ***************************************************************
   // Bus tasks and result monitor
   // ***************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   // Expectation is queued; the monitor compares when rdata lands
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      exp_q.push_back(e);
      @(negedge clk);
      rd_en = 1'b0;
   endtask
   task automatic finish_test;
      $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) rd_p <= rd_en;
   always @(negedge clk) begin
      if (rd_p === 1'b1)
         check(rdata, exp_q.pop_front());
   end
   initial forever #5 clk = ~clk;
   initial begin
      #60000;
      n_mismatch++;
      finish_test;
   end

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      {rst, ce, wr_en, rd_en, addr, wdata} = {2'b11, 30'h0};
      {global_update_mode, error_insert_source, ref8k_input_sel} = 4'h0;
      {ref8k_output_sel, latched_clear_mode, irq_pin_mode} = 3'h0;
      {second_tick, ref8k_out, adapter_ref_clock_pin} = 3'h0;
      {port_irq_any, port_status_sel_a, port_status_sel_b} = 12'h0;
      {port_update_mode, port_update_done, brd_val} = 16'h0;
      adapter_pll_locked = 3'h7;
      void'($urandom(42));
      cyc(3);
      rst = 1'b0;
      rd(`GSG_OFS_ISRIE, 16'h0000);
      rd(`GSG_OFS_SRIE, 16'h0000);
      rd(`GSG_OFS_FSEL, 16'h0000);
      rd(12'h01A, 16'h0000);
      for (int c = 0; c < 4; c++) begin
         fn = gsg_pin_fn_t'(c);
         port_status_sel_a = 4'($urandom);
         port_status_sel_b = 4'($urandom);
         brd_val = 8'($urandom);
         for (int i = 0; i < 8; i++)
            st[i] = i[0] ? port_status_sel_b[i/2] : port_status_sel_a[i/2];
         exp_o = (fn == GSG_FN_STATUS) ? st :
                 (fn == GSG_FN_HIGH) ? 8'hFF : 8'h00;
         wr(`GSG_OFS_FSEL, {8{fn}});
         cyc(8);
         check(gpio_oe, (fn == GSG_FN_INPUT) ? 8'h00 : 8'hFF);
         if (fn != GSG_FN_INPUT)
            check(gpio_out, exp_o);
         rd(`GSG_OFS_PINRD, {8'h00, (c == 0) ? brd_val : exp_o});
      end
      // Pad 4 moved above while unselected, so no activity is latched
      rd(`GSG_OFS_SRL, 16'h0000);
      wr(`GSG_OFS_FSEL, 16'hFFFF);
      global_update_mode = `GSG_UPD_PIN;
      {error_insert_source, ref8k_input_sel, ref8k_output_sel} = 3'h7;
      ref8k_out = 1'b1;
      brd_val = 8'hA8;
      cyc(8);
      check(gpio_oe, 8'h57);
      check(gpio_out & 8'h57, 8'h57);
      check({ext_update_trigger, ext_error_insert, ref8k_in}, 3'h7);
      ref8k_out = 1'b0;
      global_update_mode = 2'h2;
      cyc(2);
      check({gpio_oe[7], gpio_out[1]}, 2'b10);
      wr(`GSG_OFS_SRL, 16'hFFFF);
      rd(`GSG_OFS_SRL, 16'h0000);
      repeat (4) begin
         brd_val[3] = ~brd_val[3];
         adapter_ref_clock_pin = ~adapter_ref_clock_pin;
         cyc(6);
      end
      rd(`GSG_OFS_SRL, 16'h0018);
      wr(`GSG_OFS_SRIE, 16'h0007);
      wr(`GSG_OFS_ISRIE, 16'h0001);
      cyc(2);
      rd(`GSG_OFS_ISR, 16'h0000);
      check(irq_pad, 1'b1);
      @(negedge clk) second_tick = 1'b1;
      @(negedge clk) second_tick = 1'b0;
      cyc(2);
      rd(`GSG_OFS_ISR, 16'h0001);
      check({irq_pad, irq_n_oe}, 2'b01);
      wr(`GSG_OFS_SRL, 16'h0004);
      rd(`GSG_OFS_SRL, 16'h0018);
      check({irq_pad, irq_n_oe}, 2'b10);
      irq_pin_mode = 1'b1;
      cyc(2);
      check({irq_n_oe, irq_n_out}, 2'b11);
      adapter_pll_locked = 3'h6;
      cyc(3);
      rd(`GSG_OFS_SR, 16'h0002);
      adapter_pll_locked = 3'h7;
      cyc(3);
      rd(`GSG_OFS_SR, 16'h0000);
      rd(`GSG_OFS_SRL, 16'h001A);
      check(irq_pad, 1'b0);
      port_update_mode = 4'h5;
      port_update_done = 4'h1;
      cyc(3);
      rd(`GSG_OFS_SR, 16'h0000);
      port_update_done = 4'h5;
      cyc(3);
      // Request is modelled as held until update done reads back as 1
      rd(`GSG_OFS_SR, 16'h0001);
      latched_clear_mode = 1'b1;
      rd(`GSG_OFS_SRL, 16'h001B);
      rd(`GSG_OFS_SRL, 16'h0000);
      wr(`GSG_OFS_ISRIE, 16'h0040);
      port_irq_any = 4'h4;
      cyc(2);
      rd(`GSG_OFS_ISR, 16'h0040);
      check(irq_pad, 1'b0);
      wr(`GSG_OFS_ISRIE, 16'h0020);
      wr(`GSG_OFS_SR, 16'hFFFF);
      port_irq_any = 4'($urandom);
      cyc(2);
      check(irq_pad, !port_irq_any[1]);
      rd(`GSG_OFS_ISR, {8'h00, port_irq_any, 4'h0});
      rd(`GSG_OFS_ISRIE, 16'h0020);
      // Clock enable low: neither the write nor the tick may land
      ce = 1'b0;
      second_tick = 1'b1;
      wr(`GSG_OFS_ISRIE, 16'h00F1);
      second_tick = 1'b0;
      ce = 1'b1;
      rd(`GSG_OFS_ISRIE, 16'h0020);
      rd(`GSG_OFS_SRL, 16'h0000);
      cyc(2);
      check(16'(exp_q.size()), 16'h0000);
      finish_test;
   end
endmodule
